// [design/pll_clock_source_divider_cfg.sv]
// Purpose: Clock tree source selection and PLL pre-divider/multiplier configuration
// Assumes: Control-port writes and reads arrive as one-cycle strobes on clk
// Notes: Low multiplier bytes come from adjacent registers as inputs
`timescale 1ns/100ps
// Operation
// [RULE1] A 2-bit field picks the pre-divider input clock, resetting to the primary bit clock.
// [RULE2] A 3-bit field picks the primary bit-clock divider source; 1, 6 and 7 are reserved.
// [RULE3] A 3-bit field picks the secondary bit-clock divider source; 2, 6 and 7 are reserved.
// [RULE4] A 2-bit field picks the digital NM divider input, resetting to the primary bit clock.
// [RULE5] A 2-bit field picks the analog NM input: PLL, digital source or low-jitter primary.
// [RULE6] The 8-bit pre-scaler divides by its value, code 0 divides by 256, and it resets to 1.
// [RULE7] With automatic detection on, the programmed pre-divider and multipliers are replaced.
// [RULE8] One bit holds the top bit of the integer multiplier, resetting to 0.
// [RULE9] Six bits hold the upper part of the fractional multiplier, resetting to 0.
// [RULE10] One bit makes the PLL halve its divided clock output when set.
// [RULE11] Software writes reserved bits only with their reset values.
// [RULE12] The 9-bit integer multiplier is its top bit then a low byte, with 0 reserved.
// [RULE13] The 14-bit fractional multiplier must stay at or below 9999.
module pll_clock_source_divider_cfg
   import clk_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] integer_mult_low,
   input wire logic [7:0] fraction_mult_low,
   input wire logic auto_detect_en,
   input wire logic [8:0] auto_prescale_ratio,
   input wire logic [8:0] auto_integer_mult,
   input wire logic [13:0] auto_fraction_mult,
   output logic [1:0] prescale_input_select,
   output logic [2:0] primary_bitclk_div_source,
   output logic [2:0] secondary_bitclk_div_source,
   output logic [1:0] digital_nm_source_select,
   output logic analog_nm_from_pll,
   output logic analog_nm_from_digital_source,
   output logic analog_nm_from_primary_low_jitter,
   output logic divided_clock_halve,
   output logic [8:0] prescale_ratio,
   output logic [8:0] integer_mult,
   output logic [13:0] fraction_mult,
   output logic source_code_reserved,
   output logic mult_code_reserved
);
   // ==========================================================
   // Register file
   logic [7:0] cfg12_val;
   logic [7:0] cfg13_val;
   logic [7:0] cfg14_val;
   logic [7:0] cfg15_val;
   logic [7:0] cfg16_val;
   wire sel12 = reg_wr && (reg_addr == PLL_AND_PRIMARY_BITCLK_SOURCE_OFS);
   wire sel13 = reg_wr && (reg_addr == SECONDARY_BITCLK_DIV_SOURCE_OFS);
   wire sel14 = reg_wr && (reg_addr == NM_DIVIDER_SOURCE_SELECT_OFS);
   wire sel15 = reg_wr && (reg_addr == PLL_PRESCALE_DIVIDER_OFS);
   wire sel16 = reg_wr && (reg_addr == PLL_MULTIPLIER_UPPER_OFS);

   // Read-only reserved bits are masked; writable reserved bits are stored as written
   cfg_byte_reg #(
      .RESET_VAL(PLL_AND_PRIMARY_BITCLK_SOURCE_RST),
      .WMASK(PLL_AND_PRIMARY_BITCLK_SOURCE_WMASK)
   ) u_cfg12 (
      .clk(clk),
      .rstn(rstn),
      .wr_sel(sel12),
      .wr_data(reg_wdata),
      .value(cfg12_val)
   );

   cfg_byte_reg #(
      .RESET_VAL(SECONDARY_BITCLK_DIV_SOURCE_RST),
      .WMASK(SECONDARY_BITCLK_DIV_SOURCE_WMASK)
   ) u_cfg13 (
      .clk(clk),
      .rstn(rstn),
      .wr_sel(sel13),
      .wr_data(reg_wdata),
      .value(cfg13_val)
   );

   cfg_byte_reg #(
      .RESET_VAL(NM_DIVIDER_SOURCE_SELECT_RST),
      .WMASK(ALL_BITS_WMASK)
   ) u_cfg14 (
      .clk(clk),
      .rstn(rstn),
      .wr_sel(sel14),
      .wr_data(reg_wdata),
      .value(cfg14_val)
   );

   cfg_byte_reg #(
      .RESET_VAL(PLL_PRESCALE_DIVIDER_RST),
      .WMASK(ALL_BITS_WMASK)
   ) u_cfg15 ( // RULE6
      .clk(clk),
      .rstn(rstn),
      .wr_sel(sel15),
      .wr_data(reg_wdata),
      .value(cfg15_val)
   );

   cfg_byte_reg #(
      .RESET_VAL(PLL_MULTIPLIER_UPPER_RST),
      .WMASK(ALL_BITS_WMASK)
   ) u_cfg16 ( // RULE8
      .clk(clk),
      .rstn(rstn),
      .wr_sel(sel16),
      .wr_data(reg_wdata),
      .value(cfg16_val)
   );

   // ==========================================================
   // Read path
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   always_comb begin
      unique case (reg_addr)
         PLL_AND_PRIMARY_BITCLK_SOURCE_OFS: rdata_nxt = cfg12_val;
         SECONDARY_BITCLK_DIV_SOURCE_OFS: rdata_nxt = cfg13_val;
         NM_DIVIDER_SOURCE_SELECT_OFS: rdata_nxt = cfg14_val;
         PLL_PRESCALE_DIVIDER_OFS: rdata_nxt = cfg15_val;
         PLL_MULTIPLIER_UPPER_OFS: rdata_nxt = cfg16_val;
         default: rdata_nxt = 8'h00;
      endcase
   end

   // ==========================================================
   // Field decode
   wire [1:0] pre_sel = cfg12_val[PRESCALE_INPUT_SELECT_LSB +: 2]; // RULE1
   wire [2:0] pri_src = cfg12_val[PRIMARY_BITCLK_DIV_SOURCE_LSB +: 3]; // RULE2
   wire [2:0] sec_src = cfg13_val[SECONDARY_BITCLK_DIV_SOURCE_LSB +: 3]; // RULE3
   wire [1:0] dig_nm = cfg14_val[DIGITAL_NM_SOURCE_SELECT_LSB +: 2]; // RULE4
   wire [1:0] ana_nm = cfg14_val[ANALOG_NM_SOURCE_SELECT_LSB +: 2]; // RULE5
   wire ana_pll = (ana_nm == ANA_NM_PLL_A) || (ana_nm == ANA_NM_PLL_B); // RULE5
   wire ana_dig = (ana_nm == ANA_NM_DIGITAL_SOURCE); // RULE5
   wire ana_lj = (ana_nm == ANA_NM_PRIMARY_LOW_JITTER); // RULE5
   wire halve = cfg16_val[DIVIDED_CLOCK_HALVE_POS]; // RULE10
   wire pri_bad = (pri_src == SRC3_PRIMARY_BITCLK) || (pri_src > SRC3_DSP_CLK); // RULE2
   wire sec_bad = (sec_src == SRC3_SECONDARY_BITCLK) || (sec_src > SRC3_DSP_CLK); // RULE3

   // Code 0 stands for the largest ratio, so the ratio needs nine bits
   wire [8:0] man_pdiv = (cfg15_val == 8'h00) ? PRESCALE_ZERO_RATIO : {1'b0, cfg15_val}; // RULE6
   wire [8:0] man_j = {cfg16_val[INTEGER_MULT_TOP_BIT_POS], integer_mult_low}; // RULE8 RULE12
   wire [13:0] man_d = {cfg16_val[FRACTION_MULT_TOP_BITS_LSB +: 6], fraction_mult_low}; // RULE9

   // Auto detection overrides only the ratio and multipliers, never the source selects
   wire [8:0] eff_pdiv = auto_detect_en ? auto_prescale_ratio : man_pdiv; // RULE7
   wire [8:0] eff_j = auto_detect_en ? auto_integer_mult : man_j; // RULE7
   wire [13:0] eff_d = auto_detect_en ? auto_fraction_mult : man_d; // RULE7
   wire mult_bad = (eff_j == INTEGER_MULT_RESERVED) || // RULE12
      (eff_d > FRACTION_MULT_MAX); // RULE13

   // ==========================================================
   // Output flops
   // Read data stands until the next read strobe
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   // Reserved source codes pass through and are only flagged, so software sees what it wrote
   always_ff @(posedge clk) begin
      if (!rstn) begin
         prescale_input_select <= SRC2_PRIMARY_BITCLK;
         primary_bitclk_div_source <= SRC3_PLL_OUT;
         secondary_bitclk_div_source <= SRC3_PLL_OUT;
         digital_nm_source_select <= SRC2_PRIMARY_BITCLK;
      end else begin
         prescale_input_select <= pre_sel; // RULE1
         primary_bitclk_div_source <= pri_src; // RULE2
         secondary_bitclk_div_source <= sec_src; // RULE3
         digital_nm_source_select <= dig_nm; // RULE4
      end
   end

   // One-hot analog selects keep two sources off the NM divider input at once
   always_ff @(posedge clk) begin
      if (!rstn) begin
         analog_nm_from_pll <= 1'b1;
         analog_nm_from_digital_source <= 1'b0;
         analog_nm_from_primary_low_jitter <= 1'b0;
      end else begin
         analog_nm_from_pll <= ana_pll; // RULE5
         analog_nm_from_digital_source <= ana_dig; // RULE5
         analog_nm_from_primary_low_jitter <= ana_lj; // RULE5
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         divided_clock_halve <= 1'b0;
      end else begin
         divided_clock_halve <= halve; // RULE10
      end
   end

   // Ratio and multipliers lag their registers by one edge
   always_ff @(posedge clk) begin
      if (!rstn) begin
         prescale_ratio <= {1'b0, PLL_PRESCALE_DIVIDER_RST};
         integer_mult <= 9'h000;
         fraction_mult <= 14'h0000;
      end else begin
         prescale_ratio <= eff_pdiv; // RULE6
         integer_mult <= eff_j; // RULE12
         fraction_mult <= eff_d; // RULE9
      end
   end

   // Flags only report; nothing is blocked when a code is reserved
   always_ff @(posedge clk) begin
      if (!rstn) begin
         source_code_reserved <= 1'b0;
         mult_code_reserved <= 1'b0;
      end else begin
         source_code_reserved <= pri_bad || sec_bad; // RULE2 RULE3
         mult_code_reserved <= mult_bad; // RULE13
      end
   end

   assign reg_rdata = rdata_r;
endmodule

// [design/clk_cfg_pkg.sv]
// Purpose: Constants for the clock source and PLL divider configuration block
// Assumes: Byte-wide registers on a byte-addressed control port
// Notes: Offsets are the control-port register addresses
package clk_cfg_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] PLL_AND_PRIMARY_BITCLK_SOURCE_OFS = 8'h32;
   localparam logic [7:0] SECONDARY_BITCLK_DIV_SOURCE_OFS = 8'h33;
   localparam logic [7:0] NM_DIVIDER_SOURCE_SELECT_OFS = 8'h34;
   localparam logic [7:0] PLL_PRESCALE_DIVIDER_OFS = 8'h35;
   localparam logic [7:0] PLL_MULTIPLIER_UPPER_OFS = 8'h36;
   // ==========================================================
   // Reset values
   localparam logic [7:0] PLL_AND_PRIMARY_BITCLK_SOURCE_RST = 8'h00;
   localparam logic [7:0] SECONDARY_BITCLK_DIV_SOURCE_RST = 8'h00;
   localparam logic [7:0] NM_DIVIDER_SOURCE_SELECT_RST = 8'h10;
   localparam logic [7:0] PLL_PRESCALE_DIVIDER_RST = 8'h01;
   localparam logic [7:0] PLL_MULTIPLIER_UPPER_RST = 8'h00;
   // ==========================================================
   // Writable bit masks; other bits are read-only zero
   localparam logic [7:0] PLL_AND_PRIMARY_BITCLK_SOURCE_WMASK = 8'hF8;
   localparam logic [7:0] SECONDARY_BITCLK_DIV_SOURCE_WMASK = 8'h70;
   localparam logic [7:0] ALL_BITS_WMASK = 8'hFF;
   // ==========================================================
   // Field positions
   localparam int PRESCALE_INPUT_SELECT_LSB = 6;
   localparam int PRIMARY_BITCLK_DIV_SOURCE_LSB = 3;
   localparam int SECONDARY_BITCLK_DIV_SOURCE_LSB = 4;
   localparam int DIGITAL_NM_SOURCE_SELECT_LSB = 6;
   localparam int ANALOG_NM_SOURCE_SELECT_LSB = 4;
   localparam int INTEGER_MULT_TOP_BIT_POS = 7;
   localparam int DIVIDED_CLOCK_HALVE_POS = 6;
   localparam int FRACTION_MULT_TOP_BITS_LSB = 0;
   // ==========================================================
   // Clock source codes
   localparam logic [1:0] SRC2_PRIMARY_BITCLK = 2'h0;
   localparam logic [1:0] SRC2_SECONDARY_BITCLK = 2'h1;
   localparam logic [1:0] SRC2_AUX_CONTROL_CLK = 2'h2;
   localparam logic [1:0] SRC2_INTERNAL_OSC = 2'h3;
   localparam logic [2:0] SRC3_PLL_OUT = 3'h0;
   localparam logic [2:0] SRC3_PRIMARY_BITCLK = 3'h1;
   localparam logic [2:0] SRC3_SECONDARY_BITCLK = 3'h2;
   localparam logic [2:0] SRC3_AUX_CONTROL_CLK = 3'h3;
   localparam logic [2:0] SRC3_INTERNAL_OSC = 3'h4;
   localparam logic [2:0] SRC3_DSP_CLK = 3'h5;
   localparam logic [1:0] ANA_NM_PLL_A = 2'h0;
   localparam logic [1:0] ANA_NM_PLL_B = 2'h1;
   localparam logic [1:0] ANA_NM_DIGITAL_SOURCE = 2'h2;
   localparam logic [1:0] ANA_NM_PRIMARY_LOW_JITTER = 2'h3;
   // ==========================================================
   // Pre-scaler ratio and multiplier limits
   localparam logic [8:0] PRESCALE_ZERO_RATIO = 9'h100;
   localparam logic [13:0] FRACTION_MULT_MAX = 14'h270F;
   localparam logic [8:0] INTEGER_MULT_RESERVED = 9'h000;
endpackage

// [design/cfg_byte_reg.sv]
// Purpose: One byte-wide configuration register with a write mask
// Assumes: Single-cycle write strobe synchronous to clk
// Notes: Masked-off bits hold their reset value and ignore writes
`timescale 1ns/100ps
module cfg_byte_reg #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WMASK = 8'hFF
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wr_sel,
   input wire logic [7:0] wr_data,
   output logic [7:0] value
);
   logic [7:0] value_r;
   logic [7:0] value_nxt;

   // ==========================================================
   // Storage
   // Read-only bits stay at reset even if software writes them
   assign value_nxt = (wr_data & WMASK) | (RESET_VAL & ~WMASK);
   assign value = value_r;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         value_r <= RESET_VAL;
      end else if (wr_sel) begin
         value_r <= value_nxt;
      end
   end
endmodule

// [bench/clk_cfg_properties.sv]
// Purpose: Port-level properties of the clock configuration block
// Assumes: Decoded outputs land one edge after the write edge
// Notes: Checks on following inputs skip the first edge after reset
`timescale 1ns/100ps
module clk_cfg_properties
   import clk_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic auto_detect_en,
   input wire logic divided_clock_halve,
   input wire logic analog_nm_from_pll,
   input wire logic analog_nm_from_digital_source,
   input wire logic analog_nm_from_primary_low_jitter,
   input wire logic source_code_reserved,
   input wire logic mult_code_reserved,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] integer_mult_low,
   input wire logic [1:0] prescale_input_select,
   input wire logic [2:0] primary_bitclk_div_source,
   input wire logic [2:0] secondary_bitclk_div_source,
   input wire logic [8:0] prescale_ratio,
   input wire logic [8:0] auto_prescale_ratio,
   input wire logic [8:0] integer_mult,
   input wire logic [13:0] fraction_mult
);
   // ==========================================================
   // Helpers
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire wr32 = reg_wr && reg_addr == PLL_AND_PRIMARY_BITCLK_SOURCE_OFS;
   wire wr35 = reg_wr && reg_addr == PLL_PRESCALE_DIVIDER_OFS;
   wire wr36 = reg_wr && reg_addr == PLL_MULTIPLIER_UPPER_OFS;
   // ==========================================================
   // Properties
   AST_SELECT_FIELDS: assert property (wr32 ##1 !wr32
      |=> {prescale_input_select, primary_bitclk_div_source} == $past(reg_wdata, 2) >> 3)
      else $error("source select fields wrong");
   AST_PRESCALE_RATIO: assert property (
      wr35 && !auto_detect_en ##1 !wr35 && !auto_detect_en
      |=> prescale_ratio == ($past(reg_wdata, 2) == 0 ? 9'h100 : {1'b0, $past(reg_wdata, 2)}))
      else $error("prescale ratio wrong");
   AST_UPPER_BYTE: assert property (
      wr36 && !auto_detect_en ##1 !wr36 && !auto_detect_en
      |=> {integer_mult[8], divided_clock_halve, fraction_mult[13:8]} == $past(reg_wdata, 2))
      else $error("multiplier upper byte wrong");
   AST_AUTO_OVERRIDE: assert property ($past(rstn) && $past(auto_detect_en)
      |-> prescale_ratio == $past(auto_prescale_ratio)) else $error("auto ratio not taken");
   AST_J_LOW_BYTE: assert property ($past(rstn) && !$past(auto_detect_en)
      |-> integer_mult[7:0] == $past(integer_mult_low)) else $error("integer low byte wrong");
   AST_ANALOG_ONE_HOT: assert property ($onehot({analog_nm_from_pll,
      analog_nm_from_digital_source,
      analog_nm_from_primary_low_jitter})) else $error("analog select");
   AST_SOURCE_FLAG: assert property (source_code_reserved ==
      (primary_bitclk_div_source inside {3'h1, 3'h6, 3'h7} ||
       secondary_bitclk_div_source inside {3'h2, 3'h6, 3'h7})) else $error("source flag wrong");
   AST_MULT_FLAG: assert property ($past(rstn) |-> mult_code_reserved ==
      (integer_mult == 0 || fraction_mult > FRACTION_MULT_MAX)) else $error("mult flag wrong");
   AST_READ_ONLY_33: assert property (
      reg_rd && reg_addr == SECONDARY_BITCLK_DIV_SOURCE_OFS
      |=> (reg_rdata & 8'h8F) == 8'h00) else $error("reserved bits not zero");
endmodule
bind pll_clock_source_divider_cfg clk_cfg_properties i_clk_cfg_properties (.clk, .rstn,
   .reg_wr, .reg_rd, .auto_detect_en, .divided_clock_halve, .analog_nm_from_pll,
   .analog_nm_from_digital_source, .analog_nm_from_primary_low_jitter, .source_code_reserved,
   .mult_code_reserved, .reg_addr, .reg_wdata, .reg_rdata, .integer_mult_low,
   .prescale_input_select, .primary_bitclk_div_source, .secondary_bitclk_div_source,
   .prescale_ratio, .auto_prescale_ratio, .integer_mult, .fraction_mult);

// [bench/test_pll_clock_source_divider_cfg.sv]
// Purpose: Self-checking bench for the clock configuration block
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Every wait is a fixed count taken from the port timing
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module test_pll_clock_source_divider_cfg
   import clk_cfg_pkg::*;
;
   logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, auto_detect_en = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, integer_mult_low = 8'h00;
   logic [7:0] fraction_mult_low = 8'h00, reg_rdata;
   logic [8:0] auto_prescale_ratio = 9'h000, auto_integer_mult = 9'h000, prescale_ratio;
   logic [8:0] integer_mult;
   logic [13:0] auto_fraction_mult = 14'h0000, fraction_mult;
   logic [1:0] prescale_input_select, digital_nm_source_select;
   logic [2:0] primary_bitclk_div_source, secondary_bitclk_div_source;
   logic analog_nm_from_pll, analog_nm_from_digital_source, analog_nm_from_primary_low_jitter;
   logic divided_clock_halve, source_code_reserved, mult_code_reserved;
   logic [7:0] rst_tab [5] = '{8'h00, 8'h00, 8'h10, 8'h01, 8'h00};
   // Writable fields set, reserved bits left at their reset values
   logic [7:0] mask_tab [5] = '{8'hF8, 8'h70, 8'hF0, 8'hFF, 8'hFF};
   int fails = 0, tests_run = 0;
   always #25 clk = ~clk;
   pll_clock_source_divider_cfg i_pll_clock_source_divider_cfg (.clk, .rstn, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .integer_mult_low, .fraction_mult_low, .auto_detect_en,
      .auto_prescale_ratio, .auto_integer_mult, .auto_fraction_mult, .prescale_input_select,
      .primary_bitclk_div_source, .secondary_bitclk_div_source, .digital_nm_source_select,
      .analog_nm_from_pll, .analog_nm_from_digital_source, .analog_nm_from_primary_low_jitter,
      .divided_clock_halve, .prescale_ratio, .integer_mult, .fraction_mult,
      .source_code_reserved, .mult_code_reserved);
   // ==========================================================
   // Port tasks
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr(input logic [7:0] a, d);
      tick(1);
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      tick(1);
      reg_wr = 0;
   endtask
   task rd(input logic [7:0] a, e);
      tick(1);
      {reg_rd, reg_addr} = {1'b1, a};
      tick(1);
      reg_rd = 0;
      `CHK(reg_rdata, e)
   endtask
   // ==========================================================
   // Scenarios
   task reset_and_masks;
      `CHK(prescale_ratio, 9'h001)
      for (int i = 0; i < 5; i++) rd(8'(8'h32 + i), rst_tab[i]);
      for (int i = 0; i < 5; i++) begin
         wr(8'(8'h32 + i), mask_tab[i]);
         rd(8'(8'h32 + i), mask_tab[i]);
      end
      wr(8'h37, 8'hFF);
      rd(8'h37, 8'h00);
      `CHK({integer_mult[8], divided_clock_halve, fraction_mult[13:8]}, 8'hFF)
      `CHK(prescale_ratio, 9'h0FF)
   endtask
   task source_codes;
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         wr(8'h32, {c[1:0], c, 3'h0});
         wr(8'h33, 8'h00);
         wr(8'h34, {c[1:0], c[1:0], 4'h0});
         wr(8'h35, 8'(i * 36));
         tick(1);
         `CHK({prescale_input_select, primary_bitclk_div_source}, {c[1:0], c})
         `CHK(source_code_reserved, c inside {3'h1, 3'h6, 3'h7})
         `CHK(digital_nm_source_select, c[1:0])
         `CHK({analog_nm_from_pll, analog_nm_from_digital_source, analog_nm_from_primary_low_jitter},
            {c[1:0] < 2'h2, c[1:0] == 2'h2, c[1:0] == 2'h3})
         `CHK(prescale_ratio, (i == 0) ? PRESCALE_ZERO_RATIO : 9'(i * 36))
         wr(8'h32, 8'h00);
         wr(8'h33, {1'b0, c, 4'h0});
         tick(1);
         `CHK({secondary_bitclk_div_source, source_code_reserved},
            {c, c inside {3'h2, 3'h6, 3'h7}})
      end
   endtask
   task multipliers_and_auto;
      wr(8'h36, 8'h27);
      fraction_mult_low = 8'h0F;
      tick(2);
      `CHK({integer_mult, mult_code_reserved}, {9'h000, 1'b1})
      integer_mult_low = 8'h01;
      tick(2);
      `CHK({fraction_mult, mult_code_reserved}, {FRACTION_MULT_MAX, 1'b0})
      fraction_mult_low = 8'h10;
      tick(2);
      `CHK(mult_code_reserved, 1'b1)
      {auto_prescale_ratio, auto_integer_mult, auto_fraction_mult} = {9'h1AB, 9'h155, 14'h0100};
      auto_detect_en = 1;
      tick(2);
      `CHK({prescale_ratio, integer_mult, fraction_mult, mult_code_reserved},
         {9'h1AB, 9'h155, 14'h0100, 1'b0})
      auto_detect_en = 0;
      tick(2);
      `CHK(prescale_ratio, 9'h0FC)
   endtask
   task results;
      if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      tick(6);
      rstn = 1;
      reset_and_masks();
      source_codes();
      multipliers_and_auto();
      results();
   end
endmodule
